// ### hdl/ret_unit_pkg.sv
// constants shared by the return instruction unit
package ret_unit_pkg;
    // register word offsets, compared with address bits 5:2
    localparam logic [3:0] OFS_INSTR = 4'h0;
    localparam logic [3:0] OFS_PC = 4'h1;
    localparam logic [3:0] OFS_WORK = 4'h2;
    localparam logic [3:0] OFS_FLAGS = 4'h3;
    localparam logic [3:0] OFS_BANK = 4'h4;
    localparam logic [3:0] OFS_SHADOW = 4'h5;
    localparam logic [3:0] OFS_STACK = 4'h6;
    localparam logic [3:0] OFS_CTRL = 4'h7;
    localparam logic [3:0] OFS_LATCH = 4'h8;
    // field positions
    localparam int SHD_FLAGS_LSB = 8;
    localparam int SHD_BANK_LSB = 16;
    localparam int CTRL_GIEH_BIT = 0;
    localparam int CTRL_GIEL_BIT = 1;
    localparam int CTRL_LEVEL_BIT = 2;
    localparam int CTRL_SP_LSB = 8;
    localparam int INSTR_BUSY_BIT = 16;
    localparam int INSTR_BAD_BIT = 17;
    localparam int LATCH_UPPER_LSB = 8;
    // opcode patterns, the low bit of the two 0x001x forms is the shadow flag
    localparam logic [14:0] OPC_IRQ_RET = 15'h0008;
    localparam logic [14:0] OPC_SUB_RET = 15'h0009;
    localparam logic [7:0] OPC_LIT_RET = 8'h0c;
    // instruction cycle phases
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q4 = 2'h3;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_BANK = 4'h0;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_ALIGN = 2'b01,
        ST_EXEC = 2'b11,
        ST_FLUSH = 2'b10
    } seq_type;
endpackage : ret_unit_pkg

// ### hdl/return_instruction_unit.sv
// return instruction unit: decode and execution of the three return opcodes
module return_instruction_unit
    import ret_unit_pkg::*;
#(
    parameter int PC_W = 21,
    parameter int STACK_DEPTH = 31,
    parameter int SP_W = 5
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // avalon-mm slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // core side
    output logic [1:0] phase,
    output logic fetch_discard
);
    logic [1:0] phase_reg;
    seq_type state_reg;
    logic [15:0] opcode_reg;
    logic bad_op_reg;
    logic [PC_W-1:0] pc_reg;
    logic [7:0] work_reg;
    logic [7:0] flags_reg;
    logic [3:0] bank_select_reg;
    logic [7:0] shadow_work_reg;
    logic [7:0] shadow_flags_reg;
    logic [3:0] shadow_bank_select;
    logic high_level_global_irq_enable;
    logic low_level_global_irq_enable;
    logic level_sel_reg;
    logic [4:0] pc_upper_latch;
    logic [7:0] pc_high_latch;
    logic [PC_W-1:0] stack_reg [STACK_DEPTH];
    logic [SP_W-1:0] sp_reg;
    logic [PC_W-1:0] stack_top_entry;
    logic rvalid_reg;
    logic [31:0] readdata_reg;
    logic discard_reg;
    logic [3:0] idx;
    logic wr_ok;
    logic is_irq_ret;
    logic is_sub_ret;
    logic is_lit_ret;
    logic pop_now;
    logic shadow_now;

    assign idx = address[5:2];
    assign stack_top_entry = (sp_reg != '0) ? stack_reg[SP_W'(sp_reg - 1'b1)] : '0;
    assign is_irq_ret = (opcode_reg[15:1] == OPC_IRQ_RET);
    assign is_sub_ret = (opcode_reg[15:1] == OPC_SUB_RET);
    assign is_lit_ret = (opcode_reg[15:8] == OPC_LIT_RET);
    // every return acts only in Q4 of its first cycle
    assign pop_now = (state_reg == ST_EXEC) && (phase_reg == PH_Q4) && (is_irq_ret || is_sub_ret || is_lit_ret);
    assign shadow_now = pop_now && (is_irq_ret || is_sub_ret) && opcode_reg[0];
    // an instruction write stalls while one is in flight; reads stall for one wait cycle
    assign waitrequest = (read && !rvalid_reg) || (write && idx == OFS_INSTR && state_reg != ST_IDLE);
    assign wr_ok = write && !waitrequest;
    assign readdata = readdata_reg;
    assign phase = phase_reg;
    assign fetch_discard = discard_reg;

    always_ff @(posedge clk)
    begin
        if (!rstn)
            phase_reg <= PH_Q1;
        else
            phase_reg <= phase_reg + 2'h1;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_reg <= ST_IDLE;
            opcode_reg <= 16'h0000;
            bad_op_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                    if (wr_ok && idx == OFS_INSTR)
                    begin
                        opcode_reg <= writedata[15:0];
                        state_reg <= ST_ALIGN;
                    end
                ST_ALIGN:
                    if (phase_reg == PH_Q4)
                        state_reg <= ST_EXEC;
                ST_EXEC:
                    if (phase_reg == PH_Q4)
                    begin
                        // unknown opcodes are dropped, not executed
                        bad_op_reg <= !pop_now;
                        state_reg <= pop_now ? ST_FLUSH : ST_IDLE;
                    end
                ST_FLUSH:
                    if (phase_reg == PH_Q4)
                        state_reg <= ST_IDLE;
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            discard_reg <= 1'b0;
        else
            discard_reg <= pop_now;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            pc_reg <= '0;
            sp_reg <= '0;
        end
        else if (pop_now)
        begin
            pc_reg <= stack_top_entry;
            if (sp_reg != '0)
                sp_reg <= SP_W'(sp_reg - 1'b1);
        end
        else if (wr_ok && idx == OFS_STACK && sp_reg != SP_W'(STACK_DEPTH))
        begin
            sp_reg <= SP_W'(sp_reg + 1'b1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (wr_ok && idx == OFS_STACK && !pop_now && sp_reg != SP_W'(STACK_DEPTH))
            stack_reg[sp_reg] <= writedata[PC_W-1:0];
    end

    // literal into work register, flags kept
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            work_reg <= RST_BYTE;
            flags_reg <= RST_BYTE;
            bank_select_reg <= RST_BANK;
        end
        else if (shadow_now)
        begin
            work_reg <= shadow_work_reg;
            flags_reg <= shadow_flags_reg;
            bank_select_reg <= shadow_bank_select;
        end
        else if (pop_now && is_lit_ret)
            work_reg <= opcode_reg[7:0];
        else if (wr_ok && idx == OFS_WORK)
            work_reg <= writedata[7:0];
        else if (wr_ok && idx == OFS_FLAGS)
            flags_reg <= writedata[7:0];
        else if (wr_ok && idx == OFS_BANK)
            bank_select_reg <= writedata[3:0];
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            shadow_work_reg <= RST_BYTE;
            shadow_flags_reg <= RST_BYTE;
            shadow_bank_select <= RST_BANK;
        end
        else if (wr_ok && idx == OFS_SHADOW)
        begin
            shadow_work_reg <= writedata[7:0];
            shadow_flags_reg <= writedata[SHD_FLAGS_LSB +: 8];
            shadow_bank_select <= writedata[SHD_BANK_LSB +: 4];
        end
    end

    // re-enable the selected level; the hardware set wins over a write
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            high_level_global_irq_enable <= 1'b0;
            low_level_global_irq_enable <= 1'b0;
            level_sel_reg <= 1'b0;
        end
        else
        begin
            if (wr_ok && idx == OFS_CTRL)
            begin
                high_level_global_irq_enable <= writedata[CTRL_GIEH_BIT];
                low_level_global_irq_enable <= writedata[CTRL_GIEL_BIT];
                level_sel_reg <= writedata[CTRL_LEVEL_BIT];
            end
            if (pop_now && is_irq_ret && level_sel_reg)
                high_level_global_irq_enable <= 1'b1;
            if (pop_now && is_irq_ret && !level_sel_reg)
                low_level_global_irq_enable <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            pc_upper_latch <= 5'h00;
            pc_high_latch <= RST_BYTE;
        end
        else if (wr_ok && idx == OFS_LATCH)
        begin
            pc_high_latch <= writedata[7:0];
            pc_upper_latch <= writedata[LATCH_UPPER_LSB +: 5];
        end
    end

    // read path, unmapped offsets read zero
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rvalid_reg <= 1'b0;
            readdata_reg <= 32'h0000_0000;
        end
        else
        begin
            rvalid_reg <= read && !rvalid_reg;
            if (read && !rvalid_reg)
            begin
                readdata_reg <= 32'h0000_0000;
                if (idx == OFS_INSTR)
                    readdata_reg <= {14'h0000, bad_op_reg, state_reg != ST_IDLE, opcode_reg};
                else if (idx == OFS_PC)
                    readdata_reg[PC_W-1:0] <= pc_reg;
                else if (idx == OFS_WORK)
                    readdata_reg[7:0] <= work_reg;
                else if (idx == OFS_FLAGS)
                    readdata_reg[7:0] <= flags_reg;
                else if (idx == OFS_BANK)
                    readdata_reg[3:0] <= bank_select_reg;
                else if (idx == OFS_SHADOW)
                    readdata_reg[19:0] <= {shadow_bank_select, shadow_flags_reg, shadow_work_reg};
                else if (idx == OFS_STACK)
                    readdata_reg[PC_W-1:0] <= stack_top_entry;
                else if (idx == OFS_CTRL)
                    readdata_reg[12:0] <= {sp_reg, 5'h00, level_sel_reg,
                        low_level_global_irq_enable, high_level_global_irq_enable};
                else if (idx == OFS_LATCH)
                    readdata_reg[12:0] <= {pc_upper_latch, pc_high_latch};
            end
        end
    end

    // checks
    a_pop_to_pc: assert property (@(posedge clk) disable iff (!rstn)
        pop_now |=> pc_reg == $past(stack_top_entry))
        else $error("pc not loaded from popped top entry");
    a_irq_enable_set: assert property (@(posedge clk) disable iff (!rstn)
        pop_now && is_irq_ret |=> (level_sel_reg ? high_level_global_irq_enable : low_level_global_irq_enable))
        else $error("interrupt enable not set on interrupt return");
    a_irq_shadow_copy: assert property (@(posedge clk) disable iff (!rstn)
        pop_now && is_irq_ret && opcode_reg[0] |=> work_reg == $past(shadow_work_reg)
        && flags_reg == $past(shadow_flags_reg) && bank_select_reg == $past(shadow_bank_select))
        else $error("shadow copy missing on interrupt return");
    a_exec_two_cycles: assert property (@(posedge clk) disable iff (!rstn)
        pop_now |=> state_reg == ST_FLUSH [*4] ##1 state_reg == ST_IDLE)
        else $error("return did not take two cycles");
    a_literal_work: assert property (@(posedge clk) disable iff (!rstn)
        pop_now && is_lit_ret |=> work_reg == $past(opcode_reg[7:0]) && $stable(flags_reg))
        else $error("literal not loaded or flags changed");
    a_pop_in_q4: assert property (@(posedge clk) disable iff (!rstn)
        $changed(pc_reg) |-> $past(phase_reg) == PH_Q4 && $past(state_reg) == ST_EXEC)
        else $error("pc changed outside first-cycle Q4");
    a_latch_kept: assert property (@(posedge clk) disable iff (!rstn)
        pop_now |=> $stable(pc_upper_latch) && $stable(pc_high_latch))
        else $error("pc latch changed by a return");
    a_sub_flags_kept: assert property (@(posedge clk) disable iff (!rstn)
        pop_now && is_sub_ret && !opcode_reg[0] |=> $stable(flags_reg) && $stable(work_reg)
        && $stable(bank_select_reg))
        else $error("subroutine return without shadow touched registers");
    a_sub_shadow_copy: assert property (@(posedge clk) disable iff (!rstn)
        pop_now && is_sub_ret && opcode_reg[0] |=> work_reg == $past(shadow_work_reg)
        && flags_reg == $past(shadow_flags_reg) && bank_select_reg == $past(shadow_bank_select))
        else $error("shadow copy missing on subroutine return");
    a_discard_pulse: assert property (@(posedge clk) disable iff (!rstn)
        pop_now |=> fetch_discard ##1 !fetch_discard)
        else $error("prefetched word not discarded");

    c_irq_shadow: cover property (@(posedge clk) disable iff (!rstn) pop_now && is_irq_ret && opcode_reg[0]);
    c_literal: cover property (@(posedge clk) disable iff (!rstn) pop_now && is_lit_ret);
    c_sub_plain: cover property (@(posedge clk) disable iff (!rstn) pop_now && is_sub_ret && !opcode_reg[0]);
    c_stall: cover property (@(posedge clk) disable iff (!rstn) write && waitrequest);
endmodule : return_instruction_unit

// ### tb/return_instruction_unit_tb.sv
// self-checking bench for the return instruction unit
module return_instruction_unit_tb
    import ret_unit_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [5:0] address = 6'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [1:0] phase;
    logic fetch_discard;
    int errors = 0;
    int samples_checked = 0;
    int disc_cnt = 0;
    logic [1:0] disc_phase = 2'h0;

    return_instruction_unit i_return_instruction_unit (
        .clk(clk),
        .rstn(rstn),
        .address(address),
        .read(read),
        .write(write),
        .writedata(writedata),
        .readdata(readdata),
        .waitrequest(waitrequest),
        .phase(phase),
        .fetch_discard(fetch_discard)
    );

    always #12.5 clk = ~clk;

    // pulse counted mid-cycle, away from the edge that launches it
    always @(negedge clk)
    begin
        if (fetch_discard === 1'b1)
        begin
            disc_cnt++;
            disc_phase = phase;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // waitrequest is combinational on held inputs, so the value before the edge is the edge sample
    task automatic bus_access(input logic rd, input logic [3:0] ofs, input logic [31:0] d,
                              output logic [31:0] q);
        logic w;
        int n;
        begin
            @(posedge clk);
            address <= {ofs, 2'b00};
            writedata <= d;
            read <= rd;
            write <= ~rd;
            n = 0;
            do
            begin
                @(negedge clk);
                w = waitrequest;
                q = readdata;
                @(posedge clk);
                n++;
            end
            while (w !== 1'b0 && n < 200);
            // a bus that never answers counts as a mismatch
            if (w !== 1'b0)
                errors++;
            read <= 1'b0;
            write <= 1'b0;
        end
    endtask : bus_access

    task automatic wr(input logic [3:0] ofs, input logic [31:0] d);
        logic [31:0] q;
        bus_access(1'b0, ofs, d, q);
    endtask : wr

    task automatic rd_check(input string what, input logic [3:0] ofs, input logic [31:0] exp);
        logic [31:0] q;
        bus_access(1'b1, ofs, 32'h0, q);
        check(what, q, exp);
    endtask : rd_check

    task automatic wait_idle();
        logic [31:0] q;
        int n;
        begin
            n = 0;
            do
            begin
                bus_access(1'b1, OFS_INSTR, 32'h0, q);
                n++;
            end
            while (q[INSTR_BUSY_BIT] !== 1'b0 && n < 50);
            if (q[INSTR_BUSY_BIT] !== 1'b0)
                errors++;
        end
    endtask : wait_idle

    // common frame: known live, shadow and latch values, one stacked address, then one return
    task automatic do_ret(input logic [15:0] op, input logic [31:0] cpre, input logic [31:0] ectrl,
                          input logic [7:0] ew, input logic [7:0] ef, input logic [3:0] eb);
        int n0;
        begin
            wr(OFS_WORK, 32'h11);
            wr(OFS_FLAGS, 32'h22);
            wr(OFS_BANK, 32'h3);
            wr(OFS_SHADOW, 32'h000a5ce7);
            wr(OFS_LATCH, 32'h1f34);
            wr(OFS_CTRL, cpre);
            wr(OFS_STACK, 32'h12345);
            n0 = disc_cnt;
            wr(OFS_INSTR, {16'h0, op});
            wait_idle();
            rd_check("pc", OFS_PC, 32'h12345);
            rd_check("work", OFS_WORK, {24'h0, ew});
            rd_check("flags", OFS_FLAGS, {24'h0, ef});
            rd_check("bank", OFS_BANK, {28'h0, eb});
            rd_check("ctrl", OFS_CTRL, ectrl);
            rd_check("latch", OFS_LATCH, 32'h1f34);
            rd_check("stack top", OFS_STACK, 32'h0);
            check("discards", disc_cnt, n0 + 1);
            check("discard phase", {30'h0, disc_phase}, {30'h0, PH_Q1});
        end
    endtask : do_ret

    task automatic t_reset();
        rd_check("pc rst", OFS_PC, 32'h0);
        rd_check("work rst", OFS_WORK, 32'h0);
        rd_check("ctrl rst", OFS_CTRL, 32'h0);
        rd_check("unmapped", 4'h9, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_irq_return();
        // both shadow settings, both priority levels
        do_ret(16'h0010, 32'h4, 32'h5, 8'h11, 8'h22, 4'h3);
        do_ret(16'h0011, 32'h4, 32'h5, 8'he7, 8'h5c, 4'ha);
        do_ret(16'h0011, 32'h0, 32'h2, 8'he7, 8'h5c, 4'ha);
        $display("test interrupt return done");
    endtask : t_irq_return

    task automatic t_sub_return();
        do_ret(16'h0012, 32'h4, 32'h4, 8'h11, 8'h22, 4'h3);
        do_ret(16'h0013, 32'h0, 32'h0, 8'he7, 8'h5c, 4'ha);
        $display("test subroutine return done");
    endtask : t_sub_return

    task automatic t_lit_return();
        // literal boundaries 0 and 255
        do_ret(16'h0c00, 32'h0, 32'h0, 8'h00, 8'h22, 4'h3);
        do_ret(16'h0cff, 32'h0, 32'h0, 8'hff, 8'h22, 4'h3);
        $display("test literal return done");
    endtask : t_lit_return

    task automatic t_back_to_back();
        int n0;
        begin
            wr(OFS_FLAGS, 32'h81);
            wr(OFS_SHADOW, 32'h0);
            wr(OFS_STACK, 32'h00100);
            wr(OFS_STACK, 32'h00200);
            n0 = disc_cnt;
            // second opcode stalls until the first has finished
            wr(OFS_INSTR, 32'h0c5a);
            wr(OFS_INSTR, 32'h0012);
            wait_idle();
            rd_check("b2b pc", OFS_PC, 32'h00100);
            rd_check("b2b work", OFS_WORK, 32'h5a);
            rd_check("b2b flags", OFS_FLAGS, 32'h81);
            check("b2b discards", disc_cnt, n0 + 2);
            $display("test back to back done");
        end
    endtask : t_back_to_back

    // unknown opcode is dropped, then a reset in mid-run clears the state
    task automatic t_unknown_and_reset();
        begin
            wr(OFS_INSTR, 32'h0001);
            wait_idle();
            rd_check("unknown op", OFS_INSTR, 32'h00020001);
            rd_check("unknown pc", OFS_PC, 32'h00100);
            wr(OFS_WORK, 32'h77);
            rstn <= 1'b0;
            repeat (12) @(posedge clk);
            rstn <= 1'b1;
            rd_check("pc mid rst", OFS_PC, 32'h0);
            rd_check("work mid rst", OFS_WORK, 32'h0);
            rd_check("ctrl mid rst", OFS_CTRL, 32'h0);
            rd_check("instr mid rst", OFS_INSTR, 32'h0);
            $display("test unknown opcode and reset done");
        end
    endtask : t_unknown_and_reset

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        complete_run();
    end

    initial
    begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_irq_return();
        t_sub_return();
        t_lit_return();
        t_back_to_back();
        t_unknown_and_reset();
        complete_run();
    end
endmodule : return_instruction_unit_tb
